// >>> pcg_crc.sv
// programmable checksum generator with word fifo, serial shifter and interrupt
//
// Contract
// - polynomial up to 32 bits; word width set independently of polynomial length.
// - module_on bit 15 enables the whole generator; cleared disables it.
// - idle_halt bit 13 stops the generator while the device is idle.
// - fifo_word_count bits 12-8 reports valid words; limit 8 or 16 by length.
// - fifo_full_flag bit 7 set by hardware while fifo cannot accept words.
// - fifo_empty_flag bit 6 high when no words remain; resets to one.
// - irq_source_select bit 5: one fires on fifo empty, zero on shift done.
// - shifter_run bit 4 starts shifter; software or hardware may clear it.
// - lsb_first_select bit 3 shifts words lsb first; cleared shifts msb first.
// - calc_method_select bit 2 picks alternate method; cleared picks legacy method.
// - word_width_minus_one bits 12-8 of high control sets the word width.
// - poly_length_minus_one bits 4-0 of high control sets shift register length.
// - low polynomial bits 15-1 enable feedback terms; bit 0 reads zero.
// - high polynomial bits 15-0 enable feedback terms 31 down to 16.
//
// The register offsets and strobed register access were left to the implementer.
`timescale 1ns/10ps
`include "pcg_defines.svh"
module pcg_crc (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic device_idle,
    input wire logic [`PCG_ADDR_W-1:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [15:0] reg_rdata,
    output logic irq
);
    logic device_idle_meta_reg;
    logic device_idle_sync_reg;
    logic [15:0] ctrl_low_reg;
    logic [15:0] ctrl_high_reg;
    logic [15:0] poly_low_reg;
    logic [15:0] poly_high_reg;
    logic [15:0] data_low_reg;
    logic [31:0] checksum_reg;
    logic [31:0] fifo_mem [`PCG_FIFO_DEPTH];
    logic [3:0] wr_ptr_reg;
    logic [3:0] rd_ptr_reg;
    logic [4:0] count_reg;
    logic [31:0] shift_word_reg;
    logic [4:0] bit_cnt_reg;
    pcg_pkg::pcg_state_t state_reg;
    logic [`PCG_IRQ_BITS-1:0] irq_status_reg;
    logic [`PCG_IRQ_BITS-1:0] irq_mask_reg;
    logic [15:0] rdata_next;
    logic module_on;
    logic active;
    logic running;
    logic lsb_first;
    logic alt_method;
    logic [4:0] word_width_minus_one;
    logic [4:0] poly_length_minus_one;
    logic [31:0] poly;
    logic [31:0] len_mask;
    logic [4:0] fifo_limit;
    logic fifo_full;
    logic fifo_empty;
    logic push;
    logic pop;
    logic shift_step;
    logic data_bit;
    logic feedback;
    logic [31:0] checksum_next;
    logic shift_done;
    logic empty_event;
    logic wr_ctrl_low;
    logic wr_ctrl_high;
    logic wr_poly_low;
    logic wr_poly_high;
    logic wr_data_low;
    logic wr_data_high;
    logic wr_irq_status;
    logic wr_irq_mask;

    // idle request comes from the power controller, outside this clock's logic
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            device_idle_meta_reg <= 1'b0;
            device_idle_sync_reg <= 1'b0;
        end else begin
            device_idle_meta_reg <= device_idle;
            device_idle_sync_reg <= device_idle_meta_reg;
        end
    end

    assign module_on = ctrl_low_reg[`PCG_BIT_MODULE_ON];
    assign active = module_on && !(ctrl_low_reg[`PCG_BIT_IDLE_HALT] && device_idle_sync_reg);
    assign running = active && ctrl_low_reg[`PCG_BIT_RUN];
    assign lsb_first = ctrl_low_reg[`PCG_BIT_LSB_FIRST];
    assign alt_method = ctrl_low_reg[`PCG_BIT_CALC_METHOD];
    assign word_width_minus_one = ctrl_high_reg[12:8];
    assign poly_length_minus_one = ctrl_high_reg[4:0];
    assign poly = {poly_high_reg, poly_low_reg[15:1], 1'b0};
    assign len_mask = 32'hFFFFFFFF >> (5'd31 - poly_length_minus_one);
    // the two depth ranges overlap at seven; seven takes the shallow limit
    assign fifo_limit = (poly_length_minus_one >= `PCG_PLEN_SHALLOW_MIN) ?
        `PCG_FIFO_SHALLOW_LIMIT : `PCG_FIFO_DEEP_LIMIT;
    assign fifo_full = (count_reg >= fifo_limit);
    assign fifo_empty = (count_reg == 5'h00);
    // one write decode per register except the result halves, which the checksum process decodes itself
    assign wr_ctrl_low = reg_write && (reg_addr == `PCG_OFS_CTRL_LOW);
    assign wr_ctrl_high = reg_write && (reg_addr == `PCG_OFS_CTRL_HIGH);
    assign wr_poly_low = reg_write && (reg_addr == `PCG_OFS_POLY_LOW);
    assign wr_poly_high = reg_write && (reg_addr == `PCG_OFS_POLY_HIGH);
    assign wr_data_low = reg_write && (reg_addr == `PCG_OFS_DATA_LOW);
    assign wr_data_high = reg_write && (reg_addr == `PCG_OFS_DATA_HIGH);
    assign wr_irq_status = reg_write && (reg_addr == `PCG_OFS_IRQ_STATUS);
    assign wr_irq_mask = reg_write && (reg_addr == `PCG_OFS_IRQ_MASK);
    // a word is pushed by writing the high data half; pushes while full are dropped
    // words written while the module is off are lost, the fifo is held flushed
    assign push = wr_data_high && module_on && !fifo_full;
    assign pop = running && (state_reg == pcg_pkg::PCG_IDLE) && !fifo_empty;
    assign shift_step = running && (state_reg == pcg_pkg::PCG_SHIFT);

    // bit selection by direction; msb first starts at the top of the configured width
    assign data_bit = lsb_first ? shift_word_reg[0] : shift_word_reg[word_width_minus_one];

    always_comb begin
        feedback = 1'b0;
        checksum_next = checksum_reg;
        if (alt_method) begin
            // alternate: data enters with the feedback at the register output
            feedback = checksum_reg[poly_length_minus_one] ^ data_bit;
            checksum_next = ((checksum_reg << 1) ^ (feedback ? poly : 32'h00000000)) & len_mask;
            checksum_next[0] = feedback;
        end else begin
            // legacy: data enters at the bottom, feedback from the top term
            feedback = checksum_reg[poly_length_minus_one];
            checksum_next = ((checksum_reg << 1) ^ (feedback ? poly : 32'h00000000)) & len_mask;
            checksum_next[0] = data_bit ^ feedback;
        end
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            fifo_mem[0] <= 32'h00000000;
        end else if (push) begin
            fifo_mem[wr_ptr_reg] <= {reg_wdata, data_low_reg};
        end
    end

    always_ff @(posedge mclk) begin
        if (!reset_n || !module_on) begin
            wr_ptr_reg <= 4'h0;
        end else if (push) begin
            wr_ptr_reg <= wr_ptr_reg + 4'h1;
        end
    end

    always_ff @(posedge mclk) begin
        if (!reset_n || !module_on) begin
            rd_ptr_reg <= 4'h0;
        end else if (pop) begin
            rd_ptr_reg <= rd_ptr_reg + 4'h1;
        end
    end

    // a push and a pop in one cycle leave the count unchanged
    always_ff @(posedge mclk) begin
        if (!reset_n || !module_on) begin
            count_reg <= 5'h00;
        end else begin
            if (push && !pop) begin
                count_reg <= count_reg + 5'h01;
            end else if (pop && !push) begin
                count_reg <= count_reg - 5'h01;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (!reset_n || !module_on) begin
            state_reg <= pcg_pkg::PCG_IDLE;
            shift_word_reg <= 32'h00000000;
            bit_cnt_reg <= 5'h00;
        end else if (pop) begin
            state_reg <= pcg_pkg::PCG_LOAD;
            shift_word_reg <= fifo_mem[rd_ptr_reg];
            bit_cnt_reg <= word_width_minus_one;
        end else if (running) begin
            unique case (state_reg)
                pcg_pkg::PCG_IDLE: begin
                    state_reg <= pcg_pkg::PCG_IDLE;
                end
                pcg_pkg::PCG_LOAD: begin
                    state_reg <= pcg_pkg::PCG_SHIFT;
                end
                pcg_pkg::PCG_SHIFT: begin
                    shift_word_reg <= lsb_first ? (shift_word_reg >> 1) : (shift_word_reg << 1);
                    bit_cnt_reg <= bit_cnt_reg - 5'h01;
                    if (bit_cnt_reg == 5'h00) begin
                        state_reg <= pcg_pkg::PCG_IDLE;
                    end
                end
                default: begin
                    state_reg <= pcg_pkg::PCG_IDLE;
                end
            endcase
        end
    end

    assign shift_done = shift_step && (bit_cnt_reg == 5'h00) && fifo_empty;
    assign empty_event = pop && (count_reg == 5'h01) && !push;

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            checksum_reg <= 32'h00000000;
        end else if (reg_write && reg_addr == `PCG_OFS_RESULT_LOW && module_on && !running) begin
            checksum_reg <= {checksum_reg[31:16], reg_wdata};
        end else if (reg_write && reg_addr == `PCG_OFS_RESULT_HIGH && module_on && !running) begin
            checksum_reg <= {reg_wdata, checksum_reg[15:0]};
        end else if (shift_step) begin
            checksum_reg <= checksum_next;
        end
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            ctrl_low_reg <= 16'h0000;
        end else if (wr_ctrl_low) begin
            // a software write in the cycle of the hardware clear wins
            ctrl_low_reg <= reg_wdata & `PCG_CTRL_LOW_WMASK;
        end else if (shift_done) begin
            ctrl_low_reg[`PCG_BIT_RUN] <= 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            ctrl_high_reg <= 16'h0000;
        end else if (wr_ctrl_high) begin
            ctrl_high_reg <= reg_wdata & `PCG_CTRL_HIGH_WMASK;
        end
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            poly_low_reg <= 16'h0000;
        end else if (wr_poly_low) begin
            poly_low_reg <= reg_wdata & `PCG_POLY_LOW_WMASK;
        end
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            poly_high_reg <= 16'h0000;
        end else if (wr_poly_high) begin
            poly_high_reg <= reg_wdata;
        end
    end

    // low half waits here until the high half write pushes the whole word
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            data_low_reg <= 16'h0000;
        end else if (wr_data_low) begin
            data_low_reg <= reg_wdata;
        end
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            irq_mask_reg <= '0;
        end else if (wr_irq_mask) begin
            irq_mask_reg <= reg_wdata[`PCG_IRQ_BITS-1:0];
        end
    end

    // status bit 0: selected checksum event; bit 1: word pushed while full; set beats clear
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            irq_status_reg <= '0;
        end else begin
            irq_status_reg[0] <= (irq_status_reg[0] && !(wr_irq_status && reg_wdata[0])) ||
                (ctrl_low_reg[`PCG_BIT_IRQ_SEL] ? empty_event : shift_done);
            // a dropped word is reported so software can see the overrun
            irq_status_reg[1] <= (irq_status_reg[1] && !(wr_irq_status && reg_wdata[1])) ||
                (wr_data_high && module_on && fifo_full);
        end
    end

    assign irq = |(irq_status_reg & irq_mask_reg);

    always_comb begin
        rdata_next = 16'h0000;
        unique case (reg_addr)
            `PCG_OFS_CTRL_LOW: begin
                rdata_next = ctrl_low_reg;
                rdata_next[12:8] = count_reg;
                rdata_next[`PCG_BIT_FULL] = fifo_full;
                rdata_next[`PCG_BIT_EMPTY] = fifo_empty;
            end
            `PCG_OFS_CTRL_HIGH: begin
                rdata_next = ctrl_high_reg;
            end
            `PCG_OFS_POLY_LOW: begin
                rdata_next = poly_low_reg;
            end
            `PCG_OFS_POLY_HIGH: begin
                rdata_next = poly_high_reg;
            end
            `PCG_OFS_DATA_LOW: begin
                rdata_next = data_low_reg;
            end
            `PCG_OFS_RESULT_LOW: begin
                rdata_next = checksum_reg[15:0];
            end
            `PCG_OFS_RESULT_HIGH: begin
                rdata_next = checksum_reg[31:16];
            end
            `PCG_OFS_IRQ_STATUS: begin
                rdata_next[`PCG_IRQ_BITS-1:0] = irq_status_reg;
            end
            `PCG_OFS_IRQ_MASK: begin
                rdata_next[`PCG_IRQ_BITS-1:0] = irq_mask_reg;
            end
            default: rdata_next = 16'h0000;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            reg_rdata <= 16'h0000;
        end else if (reg_read) begin
            reg_rdata <= rdata_next;
        end else begin
            reg_rdata <= 16'h0000;
        end
    end
endmodule : pcg_crc

// >>> pcg_crc_assertions.sv
// port assertions of the checksum generator
`timescale 1ns/10ps
`include "pcg_defines.svh"
module pcg_crc_assertions (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic device_idle,
    input wire logic [`PCG_ADDR_W-1:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [15:0] reg_rdata,
    input wire logic irq
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);
    property p_rdata_idle; !reg_read |=> reg_rdata == 16'h0000; endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data not zero");
    property p_poly_bit0; reg_read && reg_addr == `PCG_OFS_POLY_LOW |=> !reg_rdata[0]; endproperty
    a_poly_bit0: assert property (p_poly_bit0) else $error("poly bit0 set");
    property p_low_unused; reg_read && reg_addr == `PCG_OFS_CTRL_LOW |=> (reg_rdata & 16'h4003) == 16'h0000; endproperty
    a_low_unused: assert property (p_low_unused) else $error("ctrl low unused bits set");
    property p_high_unused; reg_read && reg_addr == `PCG_OFS_CTRL_HIGH |=> (reg_rdata & 16'hE0E0) == 16'h0000; endproperty
    a_high_unused: assert property (p_high_unused) else $error("ctrl high unused bits set");
    property p_count_max; reg_read && reg_addr == `PCG_OFS_CTRL_LOW |=> reg_rdata[12:8] <= 5'h10; endproperty
    a_count_max: assert property (p_count_max) else $error("word count too large");
    property p_empty; reg_read && reg_addr == `PCG_OFS_CTRL_LOW |=> reg_rdata[6] == (reg_rdata[12:8] == 5'h00); endproperty
    a_empty: assert property (p_empty) else $error("empty flag wrong");
    property p_full; reg_read && reg_addr == `PCG_OFS_CTRL_LOW ##1 reg_rdata[7] |-> reg_rdata[12:8] inside {5'h08, 5'h10};
    endproperty
    a_full: assert property (p_full) else $error("full flag below limit");
    property p_mask_zero; reg_write && reg_addr == `PCG_OFS_IRQ_MASK && reg_wdata == 16'h0000 |=> !irq; endproperty
    a_mask_zero: assert property (p_mask_zero) else $error("irq while masked");
    property p_high_back; reg_write && reg_addr == `PCG_OFS_CTRL_HIGH ##2 reg_read && reg_addr == `PCG_OFS_CTRL_HIGH
        |=> reg_rdata == ($past(reg_wdata, 3) & 16'h1F1F); endproperty
    a_high_back: assert property (p_high_back) else $error("ctrl high readback wrong");
endmodule : pcg_crc_assertions

// >>> pcg_crc_tb_top.sv
// self-checking bench of the checksum generator
`timescale 1ns/10ps
`include "pcg_defines.svh"
module pcg_crc_tb_top;
    logic mclk = 1'b0;
    logic reset_n = 1'b0;
    logic device_idle = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [15:0] reg_wdata = 16'h0000;
    logic reg_write = 1'b0;
    logic reg_read = 1'b0;
    logic [15:0] reg_rdata;
    logic irq;
    int bad_count = 0;
    int checks = 0;
    logic [15:0] rv;
    logic [15:0] cfg;
    logic [7:0] exp_crc;
    always #5 mclk = ~mclk;
    pcg_crc u_pcg_crc (
        .mclk(mclk),
        .reset_n(reset_n),
        .device_idle(device_idle),
        .reg_addr(reg_addr),
        .reg_wdata(reg_wdata),
        .reg_write(reg_write),
        .reg_read(reg_read),
        .reg_rdata(reg_rdata),
        .irq(irq)
    );
    task automatic complete_run;
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : complete_run
    task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge mclk);
        reg_write <= 1'b0;
        #1;
    endtask : wr
    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge mclk);
        reg_read <= 1'b0;
        #1 d = reg_rdata;
    endtask : rd
    task automatic rc(input logic [3:0] a, input logic [15:0] e, input string nm);
        rd(a, rv);
        chk(nm, rv, e);
    endtask : rc
    task automatic push(input logic [7:0] w);
        wr(`PCG_OFS_DATA_LOW, {8'h00, w});
        wr(`PCG_OFS_DATA_HIGH, 16'h0000);
    endtask : push
    task automatic wait_run;
        for (int t = 0; t < 100; t++) begin
            rd(`PCG_OFS_CTRL_LOW, rv);
            if (rv[`PCG_BIT_RUN] === 1'b0) return;
        end
        bad_count++;
        $display("[ERR] run_bit expected 0 seen 1");
        complete_run;
    endtask : wait_run
    // 8-bit reference for polynomial x^8+x^2+x+1, implicit x^0 from the shifted-in feedback
    function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] w, input logic alt, input logic lsb);
        logic d;
        logic fb;
        for (int b = 0; b < 8; b++) begin
            d = lsb ? w[b] : w[7-b];
            fb = c[7] ^ (alt & d);
            c = {c[6:0], fb} ^ (fb ? 8'h06 : 8'h00);
            c[0] = c[0] ^ (~alt & d);
        end
        return c;
    endfunction : crc8
    initial begin
        repeat (3) @(posedge mclk);
        reset_n <= 1'b1;
        rc(`PCG_OFS_CTRL_LOW, 16'h0040, "ctrl_low");
        rc(`PCG_OFS_CTRL_HIGH, 16'h0000, "ctrl_high");
        chk("irq", {15'h0000, irq}, 16'h0000);
        wr(`PCG_OFS_CTRL_HIGH, 16'hFFFF);
        rc(`PCG_OFS_CTRL_HIGH, 16'h1F1F, "ctrl_high");
        wr(`PCG_OFS_POLY_LOW, 16'hFFFF);
        rc(`PCG_OFS_POLY_LOW, 16'hFFFE, "poly_low");
        wr(`PCG_OFS_POLY_HIGH, 16'hFFFF);
        rc(`PCG_OFS_POLY_HIGH, 16'hFFFF, "poly_high");
        wr(4'hF, 16'hFFFF);
        rc(4'hF, 16'h0000, "unmapped");
        $display("test registers done");
        wr(`PCG_OFS_CTRL_HIGH, 16'h0707);
        wr(`PCG_OFS_CTRL_LOW, 16'h8000);
        for (int n = 0; n < 8; n++) push(n[7:0]);
        rc(`PCG_OFS_CTRL_LOW, 16'h8880, "ctrl_low");
        push(8'hEE);
        rc(`PCG_OFS_IRQ_STATUS, 16'h0002, "irq_status");
        wr(`PCG_OFS_IRQ_MASK, 16'h0002);
        chk("irq", {15'h0000, irq}, 16'h0001);
        wr(`PCG_OFS_IRQ_STATUS, 16'h0002);
        chk("irq", {15'h0000, irq}, 16'h0000);
        wr(`PCG_OFS_IRQ_MASK, 16'h0000);
        wr(`PCG_OFS_CTRL_LOW, 16'h0000);
        rc(`PCG_OFS_CTRL_LOW, 16'h0040, "ctrl_low");
        $display("test fifo done");
        wr(`PCG_OFS_POLY_HIGH, 16'h0000);
        wr(`PCG_OFS_POLY_LOW, 16'h0007);
        // every bit order and method; the first pass also parks in idle
        for (int i = 0; i < 4; i++) begin
            cfg = {2'b10, i == 0, 7'h00, i == 3, 1'b0, i[1], i[0], 2'b00};
            wr(`PCG_OFS_CTRL_LOW, cfg);
            wr(`PCG_OFS_RESULT_LOW, 16'h0000);
            wr(`PCG_OFS_RESULT_HIGH, 16'h0000);
            push(8'hA5);
            push(8'h3C);
            exp_crc = crc8(crc8(8'h00, 8'hA5, i[0], i[1]), 8'h3C, i[0], i[1]);
            @(posedge mclk);
            device_idle <= (i == 0);
            wr(`PCG_OFS_CTRL_LOW, cfg | 16'h0010);
            if (i == 0) begin
                repeat (30) @(posedge mclk);
                rc(`PCG_OFS_CTRL_LOW, cfg | 16'h0210, "halted");
                @(posedge mclk);
                device_idle <= 1'b0;
            end
            wait_run;
            rc(`PCG_OFS_CTRL_LOW, cfg | 16'h0040, "run_clear");
            rc(`PCG_OFS_RESULT_LOW, {8'h00, exp_crc}, "result");
            rc(`PCG_OFS_IRQ_STATUS, 16'h0001, "irq_status");
            wr(`PCG_OFS_IRQ_STATUS, 16'h0001);
            $display("test checksum %0d done", i);
        end
        complete_run;
    end
endmodule : pcg_crc_tb_top
bind pcg_crc pcg_crc_assertions u_pcg_crc_assertions (
    .mclk(mclk),
    .reset_n(reset_n),
    .device_idle(device_idle),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_write(reg_write),
    .reg_read(reg_read),
    .reg_rdata(reg_rdata),
    .irq(irq)
);

// >>> pcg_defines.svh
// register offsets, field positions, fifo limits and write masks of the checksum generator
`ifndef PCG_DEFINES_SVH
`define PCG_DEFINES_SVH
`define PCG_ADDR_W 4
`define PCG_OFS_CTRL_LOW 4'h0
`define PCG_OFS_CTRL_HIGH 4'h1
`define PCG_OFS_POLY_LOW 4'h2
`define PCG_OFS_POLY_HIGH 4'h3
`define PCG_OFS_DATA_LOW 4'h4
`define PCG_OFS_DATA_HIGH 4'h5
`define PCG_OFS_RESULT_LOW 4'h6
`define PCG_OFS_RESULT_HIGH 4'h7
`define PCG_OFS_IRQ_STATUS 4'h8
`define PCG_OFS_IRQ_MASK 4'h9
`define PCG_BIT_MODULE_ON 15
`define PCG_BIT_IDLE_HALT 13
`define PCG_BIT_FULL 7
`define PCG_BIT_EMPTY 6
`define PCG_BIT_IRQ_SEL 5
`define PCG_BIT_RUN 4
`define PCG_BIT_LSB_FIRST 3
`define PCG_BIT_CALC_METHOD 2
`define PCG_FIFO_DEPTH 16
`define PCG_FIFO_DEEP_LIMIT 5'h10
`define PCG_FIFO_SHALLOW_LIMIT 5'h08
`define PCG_PLEN_SHALLOW_MIN 5'h07
`define PCG_CTRL_LOW_WMASK 16'hA03C
`define PCG_CTRL_HIGH_WMASK 16'h1F1F
`define PCG_POLY_LOW_WMASK 16'hFFFE
`define PCG_IRQ_BITS 2
`endif

// >>> pcg_pkg.sv
// types of the checksum generator
package pcg_pkg;
    typedef enum logic [1:0] {
        PCG_IDLE = 2'h0,
        PCG_LOAD = 2'h1,
        PCG_SHIFT = 2'h3
    } pcg_state_t;
endpackage : pcg_pkg
